// ===== rtl/slrh_top.sv
`include "slrh_consts.svh"
module slrh_top
  import slrh_pkg::*;
#(
  parameter int unsigned RTC_CYC = `SLRH_RTC_CYC,
  parameter int unsigned REPLY_BYTES = `SLRH_REPLY_BYTES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic is_master,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire slrh_rx_t rx_in,
  input wire logic reply_tx_done,
  input wire logic own_tx_done,
  input wire slrh_reply_in_t reply_in,
  input wire logic byte_tick,
  input wire logic stop_client_timer_cmd,
  output slrh_tx_t tx_out,
  output logic sync_pulse,
  output logic rx_enable,
  output logic resend_start,
  output logic power_down,
  output logic guard_grow,
  output logic [2:0] guard_unit,
  output logic [7:0] timer_enables,
  output logic [7:0] irq_flags
);
  localparam logic [9:0] RTC_LAST = 10'(RTC_CYC - 1);
  localparam logic [1:0] BYTE_LAST = 2'(REPLY_BYTES - 1);
  // done edge to sampled start, one rtc period plus the output register
  localparam int ACK_LAT = int'(RTC_CYC) + 1;

  slrh_state_t r;
  slrh_state_t n;
  logic [7:0] set_fl;
  logic [7:0] clr_fl;
  logic [2:0] u;
  logic [2:0] cnt_u;
  logic inc_ev;

  function automatic logic [2:0] cnt_get(logic [3:0][7:0] e, logic [2:0] i);
    if (i[0])
      cnt_get = e[i[2:1]][`SLRH_F_CNT_ODD];
    else
      cnt_get = e[i[2:1]][`SLRH_F_CNT_EVEN];
  endfunction

  function automatic logic [3:0][7:0] cnt_put(logic [3:0][7:0] e, logic [2:0] i,
                                               logic [2:0] v);
    cnt_put = e;
    if (i[0])
      cnt_put[i[2:1]][`SLRH_F_CNT_ODD] = v;
    else
      cnt_put[i[2:1]][`SLRH_F_CNT_EVEN] = v;
  endfunction

  always_comb
  begin
    n = r;
    set_fl = `SLRH_RST_BYTE;
    clr_fl = `SLRH_RST_BYTE;
    inc_ev = 1'b0;
    cnt_u = 3'h0;
    u = r.retx ? r.unit : rx_in.unit;
    n.tx.start = 1'b0;
    n.sync = 1'b0;
    n.resend = 1'b0;
    n.pdown = 1'b0;
    n.guard_grow = 1'b0;
    // software access
    if (reg_wr)
    begin
      if (reg_addr == `SLRH_ADR_TIMER_EN)
        n.ten = reg_wdata;
      else if (reg_addr == `SLRH_ADR_GUARD_LIM)
        n.lim = reg_wdata;
      else if (reg_addr == `SLRH_ADR_RETRY)
        n.ctl = reg_wdata;
      else if (reg_addr >= `SLRH_ADR_ERR0 && reg_addr <= `SLRH_ADR_ERR3)
        n.errc[2'(reg_addr - `SLRH_ADR_ERR0)] = reg_wdata;
      else if (reg_addr >= `SLRH_ADR_PAY0 && reg_addr <= `SLRH_ADR_PAY3)
        n.pay[2'(reg_addr - `SLRH_ADR_PAY0)] = reg_wdata;
      else if (reg_addr == `SLRH_ADR_ACP_CTL)
        n.acp_ctl = reg_wdata;
    end
    if (reg_rd)
    begin
      if (reg_addr == `SLRH_ADR_TIMER_EN)
        n.rdata = r.ten;
      else if (reg_addr == `SLRH_ADR_GUARD_LIM)
        n.rdata = r.lim;
      else if (reg_addr == `SLRH_ADR_RETRY)
        n.rdata = r.ctl;
      else if (reg_addr == `SLRH_ADR_STATUS)
      begin
        n.rdata = r.flags;
        clr_fl = r.flags;
      end
      else if (reg_addr >= `SLRH_ADR_ERR0 && reg_addr <= `SLRH_ADR_ERR3)
        n.rdata = r.errc[2'(reg_addr - `SLRH_ADR_ERR0)];
      else if (reg_addr >= `SLRH_ADR_PAY0 && reg_addr <= `SLRH_ADR_PAY3)
        n.rdata = r.pay[2'(reg_addr - `SLRH_ADR_PAY0)];
      else if (reg_addr == `SLRH_ADR_ACP_CTL)
        n.rdata = r.acp_ctl;
      else
        n.rdata = `SLRH_RST_BYTE;
    end
    if (stop_client_timer_cmd)
      n.ten[`SLRH_B_OWN_TIMER] = 1'b0;
    case (r.st)
      ST_IDLE:
      begin
        if (is_master && rx_in.done)
        begin
          n.unit = u;
          n.wait_cnt = 10'h000;
          if (!rx_in.id_known)
          begin
            inc_ev = 1'b1;
            cnt_u = u;
            n.guard_grow = !r.retx;
            n.guard_unit = u;
            n.retx = 1'b0;
            n.rx_en = 1'b0;
            n.pdown = 1'b1;
          end
          else if (rx_in.id_match && rx_in.crc_ok)
          begin
            n.sync = !r.retx;
            set_fl[`SLRH_FL_DAT] = 1'b1;
            if (r.acp_ctl[`SLRH_B_ACP_EN] && r.acp_ctl[`SLRH_F_SEL] == u)
              n.pend = RP_ACP;
            else
              n.pend = RP_ACK;
            n.errc = cnt_put(n.errc, u, 3'h0);
            n.retx = 1'b0;
            n.st = ST_WAIT;
          end
          else if (rx_in.id_match && r.ctl[`SLRH_F_RETRY_LIM] != 2'h0
                   && r.retx_cnt < r.ctl[`SLRH_F_RETRY_LIM])
          begin
            n.sync = !r.retx;
            set_fl[`SLRH_FL_NAR_SENT] = 1'b1;
            n.pend = RP_NAR;
            n.retx = 1'b1;
            n.retx_cnt = r.retx_cnt + `SLRH_RETRY_ONE;
            n.st = ST_WAIT;
          end
          else
          begin
            if (r.ctl[`SLRH_F_RETRY_LIM] == 2'h0)
              set_fl[`SLRH_FL_NAK] = 1'b1;
            inc_ev = 1'b1;
            cnt_u = u;
            n.pend = RP_NAK;
            n.retx = 1'b0;
            n.st = ST_WAIT;
          end
        end
        else if (!is_master && own_tx_done)
        begin
          n.pend = RP_NONE;
          n.wait_cnt = 10'h000;
          n.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        n.wait_cnt = r.wait_cnt + 10'h001;
        if (r.wait_cnt == RTC_LAST)
        begin
          if (is_master)
          begin
            n.tx.start = 1'b1;
            n.tx.code = r.pend;
            n.tx.payload = r.pay;
            n.st = ST_TX;
          end
          else if (r.pend == RP_NONE)
          begin
            n.rx_en = 1'b1;
            n.byte_cnt = 2'h0;
            n.st = ST_LISTEN;
          end
          else
          begin
            n.resend = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      ST_TX:
      begin
        if (reply_tx_done)
        begin
          n.st = ST_IDLE;
          // back to receive for the resend
          n.rx_en = r.pend == RP_NAR;
          n.pdown = r.pend != RP_NAR;
        end
      end
      ST_LISTEN:
      begin
        if (reply_in.valid)
        begin
          n.rx_en = 1'b0;
          n.st = ST_IDLE;
          n.pdown = 1'b1;
          n.retx = 1'b0;
          case (reply_in.kind)
            RP_ACK:
            begin
              set_fl[`SLRH_FL_ACK] = 1'b1;
              n.errc = cnt_put(n.errc, 3'h0, 3'h0);
            end
            RP_ACP:
            begin
              n.pay = reply_in.data;
              set_fl[`SLRH_FL_ACP] = 1'b1;
              n.errc = cnt_put(n.errc, 3'h0, 3'h0);
            end
            RP_NAR:
            begin
              set_fl[`SLRH_FL_NAR_RX] = 1'b1;
              if (r.ctl[`SLRH_F_RETRY_LIM] != 2'h0
                  && r.retx_cnt < r.ctl[`SLRH_F_RETRY_LIM])
              begin
                n.retx = 1'b1;
                n.retx_cnt = r.retx_cnt + `SLRH_RETRY_ONE;
                n.pend = RP_NAR;
                n.wait_cnt = 10'h000;
                n.st = ST_WAIT;
                n.pdown = 1'b0;
              end
            end
            default:
            begin
              set_fl[`SLRH_FL_NAK] = 1'b1;
              inc_ev = 1'b1;
            end
          endcase
        end
        else if (byte_tick)
        begin
          n.byte_cnt = r.byte_cnt + 2'h1;
          if (r.byte_cnt == BYTE_LAST)
          begin
            inc_ev = 1'b1;
            n.rx_en = 1'b0;
            n.retx = 1'b0;
            n.pdown = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      default:
        n.st = ST_IDLE;
    endcase
    if (inc_ev)
    begin
      if (cnt_get(n.errc, cnt_u) != `SLRH_CNT_MAX)
        n.errc = cnt_put(n.errc, cnt_u, cnt_get(n.errc, cnt_u) + `SLRH_CNT_ONE);
      if (cnt_get(n.errc, cnt_u) > r.lim[`SLRH_F_ERR_LIM])
        n.ten[cnt_u] = 1'b0;
    end
    if (!n.retx)
      n.retx_cnt = 2'h0;
    // hardware set wins over read clear
    n.flags = (r.flags & ~clr_fl) | set_fl;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign reg_rdata = r.rdata;
  assign tx_out = r.tx;
  assign sync_pulse = r.sync;
  assign rx_enable = r.rx_en;
  assign resend_start = r.resend;
  assign power_down = r.pdown;
  assign guard_grow = r.guard_grow;
  assign guard_unit = r.guard_unit;
  assign timer_enables = r.ten;
  assign irq_flags = r.flags;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_ack_turnaround: assert property (
    is_master && r.st == ST_IDLE && rx_in.done && rx_in.id_known && rx_in.id_match
    && rx_in.crc_ok |-> ##[ACK_LAT:ACK_LAT] (r.tx.start && r.tx.code != RP_NAK))
    else $error("reply not one rtc period after good packet");
  a_acp_payload: assert property (
    r.tx.start && r.tx.code == RP_ACP |-> r.tx.payload == r.pay)
    else $error("payload ack carries wrong data");
  a_sync_retx: assert property (
    r.sync |-> !$past(r.retx))
    else $error("timer resync during retransmission");
  a_nar_decision: assert property (
    is_master && r.st == ST_IDLE && rx_in.done && rx_in.id_known && rx_in.id_match
    && !rx_in.crc_ok && r.ctl[`SLRH_F_RETRY_LIM] != 2'h0 && !reg_wr
    && r.retx_cnt < r.ctl[`SLRH_F_RETRY_LIM]
    |=> r.flags[`SLRH_FL_NAR_SENT] && r.retx && r.errc == $past(r.errc))
    else $error("retry request handling wrong");
  a_no_reply: assert property (
    is_master && r.st == ST_IDLE && rx_in.done && !rx_in.id_known
    |=> r.st == ST_IDLE && (r.guard_grow == !$past(r.retx)) && !r.sync)
    else $error("unknown id was answered");
  a_reply_window: assert property (
    !is_master && r.st == ST_LISTEN && !reply_in.valid && byte_tick
    && r.byte_cnt == BYTE_LAST |=> r.st == ST_IDLE && !r.rx_en && r.pdown)
    else $error("reply window not closed after three bytes");
  a_flag_hold: assert property (
    !(reg_rd && reg_addr == `SLRH_ADR_STATUS)
    |=> (r.flags & $past(r.flags)) == $past(r.flags))
    else $error("interrupt flag lost without read");
  a_err_sat: assert property (
    r.errc[0][`SLRH_F_CNT_EVEN] == `SLRH_CNT_MAX && !reg_wr
    |=> r.errc[0][`SLRH_F_CNT_EVEN] inside {`SLRH_CNT_MAX, 3'h0})
    else $error("error counter wrapped");
endmodule

// ===== rtl/slrh_consts.svh
`ifndef SLRH_CONSTS_SVH
`define SLRH_CONSTS_SVH
// register addresses
`define SLRH_ADR_TIMER_EN 7'h01
`define SLRH_ADR_GUARD_LIM 7'h02
`define SLRH_ADR_RETRY 7'h03
`define SLRH_ADR_STATUS 7'h04
`define SLRH_ADR_ERR0 7'h14
`define SLRH_ADR_ERR3 7'h17
`define SLRH_ADR_PAY0 7'h2F
`define SLRH_ADR_PAY3 7'h32
`define SLRH_ADR_ACP_CTL 7'h33
// field ranges
`define SLRH_F_ERR_LIM 2:0
`define SLRH_F_GUARD 7:5
`define SLRH_F_RETRY_LIM 1:0
`define SLRH_F_SEL 6:4
`define SLRH_B_ACP_EN 7
`define SLRH_F_CNT_EVEN 2:0
`define SLRH_F_CNT_ODD 6:4
`define SLRH_B_OWN_TIMER 0
// status flag bits
`define SLRH_FL_DAT 0
`define SLRH_FL_ACK 1
`define SLRH_FL_ACP 2
`define SLRH_FL_NAK 3
`define SLRH_FL_NAR_SENT 4
`define SLRH_FL_NAR_RX 5
// reset, saturation and increment values
`define SLRH_RST_BYTE 8'h00
`define SLRH_CNT_MAX 3'h7
`define SLRH_CNT_ONE 3'h1
`define SLRH_RETRY_ONE 2'h1
// timing
`define SLRH_CLK_NS 50
`define SLRH_RTC_NS 31250
`define SLRH_RTC_CYC ((`SLRH_RTC_NS + `SLRH_CLK_NS - 1) / `SLRH_CLK_NS)
`define SLRH_REPLY_BYTES 3
`endif

// ===== rtl/slrh_pkg.sv
package slrh_pkg;
  typedef enum logic [2:0] {
    RP_NONE = 3'b000,
    RP_ACK = 3'b001,
    RP_ACP = 3'b010,
    RP_NAK = 3'b011,
    RP_NAR = 3'b100,
    RP_BAD = 3'b101
  } slrh_reply_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_TX = 2'b10,
    ST_LISTEN = 2'b11
  } slrh_fsm_t;
  typedef struct packed {
    logic done;
    logic id_known;
    logic id_match;
    logic crc_ok;
    logic [2:0] unit;
  } slrh_rx_t;
  typedef struct packed {
    logic valid;
    slrh_reply_t kind;
    logic [31:0] data;
  } slrh_reply_in_t;
  typedef struct packed {
    logic start;
    slrh_reply_t code;
    logic [31:0] payload;
  } slrh_tx_t;
  typedef struct packed {
    slrh_fsm_t st;
    logic [9:0] wait_cnt;
    logic [1:0] byte_cnt;
    logic retx;
    logic [1:0] retx_cnt;
    logic [2:0] unit;
    slrh_reply_t pend;
    logic [7:0] ten;
    logic [7:0] lim;
    logic [7:0] ctl;
    logic [3:0][7:0] errc;
    logic [3:0][7:0] pay;
    logic [7:0] acp_ctl;
    logic [7:0] flags;
    logic [7:0] rdata;
    slrh_tx_t tx;
    logic sync;
    logic rx_en;
    logic resend;
    logic pdown;
    logic guard_grow;
    logic [2:0] guard_unit;
  } slrh_state_t;
endpackage

// ===== verif/slrh_peer_model.sv
module slrh_peer_model
  import slrh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire slrh_tx_t tx_out,
  output logic reply_tx_done,
  output logic byte_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  int div;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      left <= 0;
      div <= 0;
      reply_tx_done <= 1'b0;
      byte_tick <= 1'b0;
    end
    else
    begin
      div <= (div == 4) ? 0 : div + 1;
      byte_tick <= (div == 4);
      reply_tx_done <= (left == 1);
      if (tx_out.start === 1'b1)
        left <= $urandom_range(6, 1);
      else if (left > 0)
        left <= left - 1;
    end
  end
endmodule

// ===== verif/slrh_tb_top.sv
module slrh_tb_top;
  import slrh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RC = 8;
  logic ref_clk, rst, is_master, reg_wr, reg_rd, own_tx_done, stop_client_timer_cmd;
  logic reply_tx_done, byte_tick, sync_pulse, rx_enable, resend_start, power_down;
  logic guard_grow;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, timer_enables, irq_flags, rv, ten_m, flg_m, b;
  logic [2:0] guard_unit;
  logic [31:0] pay;
  slrh_rx_t rx_in;
  slrh_reply_in_t reply_in;
  slrh_tx_t tx_out;
  int fails, n_checks, n_sync, n_grow, n_pd, n_res, n_st, lim, n, us, uo, ur, p0;
  int errc [8];
  logic [6:0] ra [6] = '{7'h01, 7'h02, 7'h03, 7'h14, 7'h2F, 7'h33};

  slrh_top #(.RTC_CYC(RC), .REPLY_BYTES(3)) dut (.ref_clk(ref_clk), .rst(rst),
    .is_master(is_master), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in), .reply_tx_done(reply_tx_done),
    .own_tx_done(own_tx_done), .reply_in(reply_in), .byte_tick(byte_tick),
    .stop_client_timer_cmd(stop_client_timer_cmd), .tx_out(tx_out),
    .sync_pulse(sync_pulse), .rx_enable(rx_enable), .resend_start(resend_start),
    .power_down(power_down), .guard_grow(guard_grow), .guard_unit(guard_unit),
    .timer_enables(timer_enables), .irq_flags(irq_flags));
  slrh_peer_model peer (.ref_clk(ref_clk), .rst(rst), .tx_out(tx_out),
    .reply_tx_done(reply_tx_done), .byte_tick(byte_tick));

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n_sync += (sync_pulse === 1'b1);
    n_grow += (guard_grow === 1'b1);
    n_pd += (power_down === 1'b1);
    n_res += (resend_start === 1'b1);
    n_st += (tx_out.start === 1'b1);
  end

  task automatic close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
  endtask

  task automatic do_rst(input logic m);
    rst = 1'b1;
    is_master = m;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    ten_m = 8'h00;
    flg_m = 8'h00;
    errc = '{default: 0};
  endtask

  task automatic bump(input int u);
    errc[u] = (errc[u] < 7) ? errc[u] + 1 : 7;
    if (errc[u] > lim)
      ten_m[u] = 1'b0;
  endtask

  task automatic chk_state(input int u);
    rd(7'h04);
    chk("flags", flg_m, rv);
    flg_m = 8'h00;
    rd(7'h14 + 7'(u / 2));
    chk("err_count", errc[u], (u % 2) ? rv[6:4] : rv[2:0]);
    chk("timer_en", ten_m, timer_enables);
  endtask

  function automatic bit hit(input int k);
    return (k == 0) ? (tx_out.start === 1'b1) : (rx_enable === (k == 1));
  endfunction

  task automatic wait_for(input int k, input int mx);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      rx_in.done = 1'b0;
      own_tx_done = 1'b0;
      n++;
    end
    while (!hit(k) && n < mx);
    if (!hit(k))
    begin
      fails++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", k);
      close_out();
    end
  endtask

  task automatic mpkt(input logic k, m, c, input int u, input slrh_reply_t code,
                      input int sy, gr);
    int s0;
    int g0;
    int t0;
    s0 = n_sync;
    g0 = n_grow;
    t0 = n_st;
    @(negedge ref_clk);
    rx_in = '{1'b1, k, m, c, 3'(u)};
    if (code == RP_NONE)
    begin
      repeat (3 * RC) @(negedge ref_clk) rx_in.done = 1'b0;
      chk("starts", t0, n_st);
      chk("grow", g0 + gr, n_grow);
      if (gr > 0)
        chk("grow_unit", u, guard_unit);
    end
    else
    begin
      wait_for(0, 4 * RC);
      chk("latency", RC + 1, n);
      chk("code", code, tx_out.code);
      if (code == RP_ACP)
        chk("payload", pay, tx_out.payload);
      repeat (12) @(negedge ref_clk);
      chk("rx_en", code == RP_NAR, rx_enable);
    end
    chk("sync", s0 + sy, n_sync);
  endtask

  task automatic cpkt(input slrh_reply_t kind, input logic [31:0] d);
    @(negedge ref_clk);
    own_tx_done = 1'b1;
    wait_for(1, 4 * RC);
    chk("listen_lat", RC + 1, n);
    if (kind == RP_NONE)
      wait_for(2, 60);
    else
    begin
      @(negedge ref_clk);
      reply_in = '{1'b1, kind, d};
      @(negedge ref_clk);
      reply_in.valid = 1'b0;
      @(negedge ref_clk);
      chk("rx_en", 0, rx_enable);
    end
  endtask

  initial
  begin
    #(60000 * 50);
    fails++;
    close_out();
  end

  initial
  begin
    ref_clk = 1'b0;
    {reg_wr, reg_rd, own_tx_done, stop_client_timer_cmd} = 4'h0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    rx_in = '0;
    reply_in = '0;
    lim = 0;
    void'($urandom(13));
    do_rst(1'b1);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset_val", 8'h00, rv);
    end
    rd(7'h7F);
    chk("unmapped", 8'h00, rv);
    wr(7'h01, 8'hFF);
    ten_m = 8'hFF;
    wr(7'h02, 8'hA1);
    lim = 1;
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      wr(7'h2F + 7'(i), b);
      pay[8 * i +: 8] = b;
    end
    us = $urandom_range(7, 0);
    uo = (us + 1) % 8;
    ur = (us + 3) % 8;
    wr(7'h33, 8'h80 | 8'(us << 4));
    mpkt(1, 0, 1, us, RP_NAK, 0, 0);
    flg_m[3] = 1'b1;
    bump(us);
    chk_state(us);
    mpkt(1, 1, 1, us, RP_ACP, 1, 0);
    flg_m[0] = 1'b1;
    errc[us] = 0;
    chk_state(us);
    mpkt(1, 1, 1, uo, RP_ACK, 1, 0);
    flg_m[0] = 1'b1;
    repeat (2)
    begin
      mpkt(1, 0, 0, uo, RP_NAK, 0, 0);
      flg_m[3] = 1'b1;
      bump(uo);
    end
    chk_state(uo);
    mpkt(0, 0, 0, (us + 2) % 8, RP_NONE, 0, 1);
    bump((us + 2) % 8);
    chk_state((us + 2) % 8);
    wr(7'h03, 8'h01);
    mpkt(1, 1, 0, ur, RP_NAR, 1, 0);
    flg_m[4] = 1'b1;
    chk_state(ur);
    mpkt(1, 1, 0, ur, RP_NAK, 0, 0);
    bump(ur);
    chk_state(ur);
    mpkt(1, 1, 0, ur, RP_NAR, 1, 0);
    mpkt(1, 1, 1, ur, RP_ACK, 0, 0);
    flg_m[4] = 1'b1;
    flg_m[0] = 1'b1;
    errc[ur] = 0;
    chk_state(ur);
    mpkt(1, 1, 0, ur, RP_NAR, 1, 0);
    mpkt(0, 0, 0, ur, RP_NONE, 0, 0);
    rd(7'h02);
    chk("guard_field", 8'hA1, rv);
    do_rst(1'b0);
    wr(7'h01, 8'h01);
    ten_m = 8'h01;
    wr(7'h02, 8'h01);
    p0 = n_pd;
    cpkt(RP_ACK, 32'h0000_0000);
    flg_m[1] = 1'b1;
    chk("pdown", p0 + 1, n_pd);
    chk_state(0);
    cpkt(RP_NAK, 32'h0000_0000);
    flg_m[3] = 1'b1;
    bump(0);
    chk_state(0);
    cpkt(RP_BAD, 32'h0000_0000);
    flg_m[3] = 1'b1;
    bump(0);
    chk_state(0);
    pay = $urandom;
    cpkt(RP_ACP, pay);
    flg_m[2] = 1'b1;
    errc[0] = 0;
    chk_state(0);
    for (int i = 0; i < 4; i++)
    begin
      rd(7'h2F + 7'(i));
      chk("acp_byte", pay[8 * i +: 8], rv);
    end
    cpkt(RP_NONE, 32'h0000_0000);
    bump(0);
    chk_state(0);
    for (int l = 0; l < 2; l++)
    begin
      wr(7'h03, 8'(l));
      p0 = n_res;
      cpkt(RP_NAR, 32'h0000_0000);
      flg_m[5] = 1'b1;
      repeat (2 * RC) @(negedge ref_clk);
      chk("resend", p0 + l, n_res);
      chk_state(0);
    end
    cpkt(RP_ACK, 32'h0000_0000);
    flg_m[1] = 1'b1;
    errc[0] = 0;
    chk_state(0);
    wr(7'h01, 8'h01);
    chk("timer_set", 8'h01, timer_enables);
    @(negedge ref_clk);
    stop_client_timer_cmd = 1'b1;
    @(negedge ref_clk);
    stop_client_timer_cmd = 1'b0;
    @(negedge ref_clk);
    chk("stop_timer", 8'h00, timer_enables);
    close_out();
  end
endmodule
